// ===== sffd_cfg.svh
// register map, field positions, reset values and rate constants of the decimation filter
`ifndef SFFD_CFG_SVH
`define SFFD_CFG_SVH

`define SFFD_ADDR_CTRL 4'h0
`define SFFD_ADDR_STATUS 4'h4
`define SFFD_ADDR_DATA 4'h8

`define SFFD_MODE_LSB 0
`define SFFD_RATE_LSB 2
`define SFFD_PHASE_BIT 5
`define SFFD_LP_BIT 6
`define SFFD_TONE_LO_BIT 7
`define SFFD_TONE_HI_BIT 8
`define SFFD_HPK_LSB 12

`define SFFD_MODE_RST 2'h2
`define SFFD_RATE_RST 3'h0
`define SFFD_HPK_RST 4'h8
`define SFFD_RATE_MAX 3'h4

`define SFFD_DIV_HR 4'h4
`define SFFD_DIV_LP 4'h8
`define SFFD_LOG2_MAX 3'h7
`define SFFD_SINC_ORDER 6'h05
`define SFFD_OUT_SCALE 22

`endif

// ===== sffd_pkg.sv
// types shared by the decimation filter
package sffd_pkg;

   typedef enum logic [1:0] {
      fm_reserved,
      fm_sinc,
      fm_sinc_lp,
      fm_sinc_lp_dc
   } sffd_mode_type;

   typedef struct packed {
      logic [3:0] hpf_k;
      logic tone_hi;
      logic tone_lo;
      logic low_power;
      logic min_phase;
      logic [2:0] rate;
      sffd_mode_type mode;
   } sffd_ctrl_type;

   typedef struct packed {
      logic valid;
      logic signed [23:0] data;
   } sffd_result_type;

endpackage

// ===== sffd_filter.sv
// sinc / tap low-pass / dc block decimation filter with avalon-mm control
//
// Overview of operation
// - The path is a variable fifth-order sinc, a fixed low-pass and a first-order dc block.
// - Output is sinc only, sinc plus low-pass or all three; one mode code is reserved.
// - The dc block is only inserted behind the sinc plus low-pass path.
// - Modulator bits arrive at clock/4, or at clock/8 in low-power mode.
// - One three-bit rate field sets the output rate of sinc and sinc plus low-pass.
// - Rate codes 0 to 4 give sinc decimation 128 to 8, or 64 to 4 in low-power mode.
// - The sinc is a length-N moving sum normalised by N and raised to the fifth power.
// - The low-pass has four subsections fed by the sinc, the first two decimating by two.
// - The third subsection decimates by four and the fourth by two, for a total of 32.
// - Subsections three and four use linear or minimum phase weights chosen by software.
// - With the low-pass the overall decimation is 4096 to 256, or half in low-power mode.
// - An optional 75 mV or 100 mV idle-tone offset is applied at the modulator input.
// - Two control bits enable the idle-tone offset and both are off after reset.
`timescale 1ns/1ps
`include "sffd_cfg.svh"
`default_nettype none

module sffd_filter (
   input wire logic clk, // 25 MHz system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic mod_bit, // modulator bitstream, one means positive
   input wire logic [3:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // write byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // low for the accepting cycle
   output sffd_pkg::sffd_result_type result, // filtered sample and valid strobe
   output logic tone_shift_sel_hi, // idle-tone offset select, upper bit
   output logic tone_shift_sel_lo // idle-tone offset select, lower bit
);

   sffd_pkg::sffd_ctrl_type ctrl;
   logic flush;
   logic [15:0] out_count;

   // register bus
   logic [31:0] ctrl_word;
   logic [31:0] lane_mask;
   logic [31:0] wr_word;
   logic [31:0] next_readdata;
   logic sel_ctrl;
   logic sel_status;
   logic sel_data;
   logic wr_ctrl;
   logic [1:0] wr_mode;
   logic [2:0] wr_rate;
   logic wr_filter_ok;
   logic wr_filter_diff;
   logic [2:0] sinc_log2;

   assign ctrl_word = {16'h0000, ctrl.hpf_k, 3'h0, ctrl.tone_hi, ctrl.tone_lo,
                       ctrl.low_power, ctrl.min_phase, ctrl.rate, ctrl.mode};
   // lanes left out keep their present bits, so one byte can be written alone
   assign lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wr_word = (ctrl_word & ~lane_mask) | (avs_writedata & lane_mask);
   assign sel_ctrl = avs_address == `SFFD_ADDR_CTRL;
   assign sel_status = avs_address == `SFFD_ADDR_STATUS;
   assign sel_data = avs_address == `SFFD_ADDR_DATA;
   assign wr_ctrl = avs_write & ~avs_waitrequest & sel_ctrl;
   assign wr_mode = wr_word[`SFFD_MODE_LSB +: 2];
   assign wr_rate = wr_word[`SFFD_RATE_LSB +: 3];
   // a reserved rate or mode code leaves the whole filter setting untouched
   assign wr_filter_ok = (wr_rate <= `SFFD_RATE_MAX) && (wr_mode != 2'h0);
   // rewriting the same setting must not flush, or a tone write would cost samples
   assign wr_filter_diff = (wr_mode != ctrl.mode) || (wr_rate != ctrl.rate)
                           || (wr_word[`SFFD_PHASE_BIT] != ctrl.min_phase)
                           || (wr_word[`SFFD_LP_BIT] != ctrl.low_power);

   // unmapped addresses read as zero and accept writes silently
   assign next_readdata = sel_ctrl ? ctrl_word :
                          sel_status ? {out_count, 13'h0000, sinc_log2} :
                          sel_data ? {{8{result.data[23]}}, result.data} :
                          32'h0000_0000;

   // one wait cycle: every request is answered on the second edge
   // a request is never refused; an unmapped address simply answers
   always_ff @(posedge clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read | avs_write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // read data is taken with the request so it stands on the accepting edge
   always_ff @(posedge clk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & avs_waitrequest) begin
         avs_readdata <= next_readdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl.mode <= sffd_pkg::sffd_mode_type'(`SFFD_MODE_RST);
         ctrl.rate <= `SFFD_RATE_RST;
         ctrl.min_phase <= 1'b0;
         ctrl.low_power <= 1'b0;
         ctrl.tone_lo <= 1'b0;
         ctrl.tone_hi <= 1'b0;
         ctrl.hpf_k <= `SFFD_HPK_RST;
      end else if (wr_ctrl) begin
         ctrl.tone_lo <= wr_word[`SFFD_TONE_LO_BIT];
         ctrl.tone_hi <= wr_word[`SFFD_TONE_HI_BIT];
         ctrl.hpf_k <= wr_word[`SFFD_HPK_LSB +: 4];
         if (wr_filter_ok) begin
            ctrl.mode <= sffd_pkg::sffd_mode_type'(wr_mode);
            ctrl.rate <= wr_rate;
            ctrl.min_phase <= wr_word[`SFFD_PHASE_BIT];
            ctrl.low_power <= wr_word[`SFFD_LP_BIT];
         end
      end
   end

   // the offset itself is analog; these flops steer it
   assign tone_shift_sel_hi = ctrl.tone_hi;
   assign tone_shift_sel_lo = ctrl.tone_lo;

   // one-cycle restart pulse after a change of filter setting
   always_ff @(posedge clk) begin
      if (srst) begin
         flush <= 1'b0;
      end else begin
         flush <= wr_ctrl & wr_filter_ok & wr_filter_diff;
      end
   end

   // modulator rate divider
   // it restarts with the filter, so the first tick after a change is a full period
   logic [3:0] mod_cnt;
   logic mod_last;
   logic mod_en;

   assign mod_last = mod_cnt == ((ctrl.low_power ? `SFFD_DIV_LP : `SFFD_DIV_HR) - 4'h1);

   always_ff @(posedge clk) begin
      if (srst | flush) begin
         mod_cnt <= 4'h0;
         mod_en <= 1'b0;
      end else begin
         mod_cnt <= mod_last ? 4'h0 : mod_cnt + 4'h1;
         mod_en <= mod_last;
      end
   end

   // fifth-order sinc
   // 40 bits hold the growth of a 128-long fifth-order sum, which needs 1 + 5 * 7 = 36 bits
   logic signed [39:0] integ [0:5];
   logic signed [39:0] comb [0:5];
   logic signed [39:0] comb_dly [0:4];
   logic [6:0] dec_cnt;
   logic [7:0] sinc_n;
   logic [5:0] sinc_shift;
   logic sinc_take;
   logic signed [63:0] sinc_wide;
   logic signed [23:0] sinc_out;
   logic sinc_vld;

   // log2 of N: 7 minus rate code, one less in low-power mode
   assign sinc_log2 = `SFFD_LOG2_MAX - ctrl.rate - {2'h0, ctrl.low_power};
   assign sinc_n = 8'h01 << sinc_log2;
   assign sinc_take = mod_en && ({1'b0, dec_cnt} == sinc_n - 8'h01);
   assign sinc_shift = {3'h0, sinc_log2} * `SFFD_SINC_ORDER;
   assign integ[0] = mod_bit ? 40'sh00_0000_0001 : -40'sh00_0000_0001;
   assign comb[0] = integ[5];

   // integrators wrap modulo 2^40; the combs undo the wrap exactly
   for (genvar k = 0; k < 5; k++) begin : g_sinc
      assign comb[k + 1] = comb[k] - comb_dly[k];
      always_ff @(posedge clk) begin
         if (srst | flush) begin
            integ[k + 1] <= 40'sh00_0000_0000;
            comb_dly[k] <= 40'sh00_0000_0000;
         end else begin
            if (mod_en) begin
               integ[k + 1] <= integ[k + 1] + integ[k];
            end
            if (sinc_take) begin
               comb_dly[k] <= comb[k];
            end
         end
      end
   end

   // normalise by N^5 and scale full scale to 2^22
   assign sinc_wide = (64'(comb[5]) <<< `SFFD_OUT_SCALE) >>> sinc_shift;

   // dec_cnt counts modulator ticks within one sinc output period
   always_ff @(posedge clk) begin
      if (srst | flush) begin
         dec_cnt <= 7'h00;
         sinc_out <= 24'sh00_0000;
         sinc_vld <= 1'b0;
      end else begin
         sinc_vld <= sinc_take;
         if (sinc_take) begin
            dec_cnt <= 7'h00;
            sinc_out <= sinc_wide[23:0];
         end else if (mod_en) begin
            dec_cnt <= dec_cnt + 7'h01;
         end
      end
   end

   // tap low-pass, four subsections
   // each subsection sums its group; the shift undoes the weight sum exactly
   logic signed [23:0] fir_d [0:4];
   logic fir_v [0:4];

   assign fir_d[0] = sinc_out;
   assign fir_v[0] = sinc_vld;

   // weights per input slot; minimum phase loads the oldest slots heavier
   // equal weights give linear phase; the minimum phase sets double the sum and shift one bit more
   function automatic logic [3:0] sffd_weight(input logic min_ph, input logic quad,
                                              input logic [1:0] idx);
      logic [3:0] w;
      w = 4'h1;
      if (min_ph && quad) begin
         w = (idx == 2'h0) ? 4'h4 : (idx == 2'h1) ? 4'h2 : 4'h1;
      end else if (min_ph) begin
         w = (idx == 2'h0) ? 4'h3 : 4'h1;
      end
      return w;
   endfunction

   for (genvar s = 0; s < 4; s++) begin : g_tap
      localparam int DEC = (s == 2) ? 4 : 2;
      localparam logic [1:0] LAST = 2'(DEC - 1);
      localparam logic [1:0] SH_BASE = (DEC == 4) ? 2'h2 : 2'h1;
      localparam logic PHASED = (s >= 2);
      logic [1:0] cnt;
      logic signed [27:0] acc;
      logic signed [27:0] prod;
      logic signed [27:0] acc_n;
      logic [3:0] w;
      logic [1:0] sh;
      logic sel_min;

      assign sel_min = ctrl.min_phase & PHASED;
      assign w = sffd_weight(sel_min, DEC == 4, cnt);
      assign sh = SH_BASE + {1'b0, sel_min};
      assign prod = 28'(fir_d[s]) * $signed({24'h00_0000, w});
      assign acc_n = ((cnt == 2'h0) ? 28'sh000_0000 : acc) + prod;

      // a flush drops a half-filled group so no output mixes two settings
      always_ff @(posedge clk) begin
         if (srst | flush) begin
            cnt <= 2'h0;
            acc <= 28'sh000_0000;
            fir_d[s + 1] <= 24'sh00_0000;
            fir_v[s + 1] <= 1'b0;
         end else begin
            fir_v[s + 1] <= 1'b0;
            if (fir_v[s]) begin
               acc <= acc_n;
               if (cnt == LAST) begin
                  cnt <= 2'h0;
                  fir_d[s + 1] <= 24'(acc_n >>> sh);
                  fir_v[s + 1] <= 1'b1;
               end else begin
                  cnt <= cnt + 2'h1;
               end
            end
         end
      end
   end

   // first-order dc block
   // the estimate is frozen unless the dc block is the selected output
   logic signed [31:0] hp_dc;
   logic signed [31:0] hp_diff;

   // dc estimate keeps 8 fraction bits; hpf_k sets the corner
   assign hp_diff = $signed({fir_d[4], 8'h00}) - hp_dc;

   always_ff @(posedge clk) begin
      if (srst | flush) begin
         hp_dc <= 32'sh0000_0000;
      end else if (fir_v[4] && ctrl.mode == sffd_pkg::fm_sinc_lp_dc) begin
         hp_dc <= hp_dc + (hp_diff >>> ctrl.hpf_k);
      end
   end

   // output selection
   // samples from sections not selected are dropped here, never queued
   always_ff @(posedge clk) begin
      if (srst | flush) begin
         result.valid <= 1'b0;
         result.data <= 24'sh00_0000;
      end else begin
         result.valid <= 1'b0;
         case (ctrl.mode)
            sffd_pkg::fm_sinc: begin
               if (sinc_vld) begin
                  result.valid <= 1'b1;
                  result.data <= sinc_out;
               end
            end
            sffd_pkg::fm_sinc_lp: begin
               if (fir_v[4]) begin
                  result.valid <= 1'b1;
                  result.data <= fir_d[4];
               end
            end
            sffd_pkg::fm_sinc_lp_dc: begin
               if (fir_v[4]) begin
                  result.valid <= 1'b1;
                  result.data <= hp_diff[31:8];
               end
            end
            default: begin
               result.valid <= 1'b0;
            end
         endcase
      end
   end

   // the result count wraps; software takes the difference of two reads
   always_ff @(posedge clk) begin
      if (srst) begin
         out_count <= 16'h0000;
      end else if (result.valid) begin
         out_count <= out_count + 16'h0001;
      end
   end

endmodule

`default_nettype wire

// ===== sffd_filter_sva.sv
// port-level assertions for the decimation filter
`timescale 1ns/1ps
`default_nettype none
module sffd_filter_sva (
   input wire logic clk, // clock
   input wire logic srst, // reset
   input wire logic [3:0] avs_address, // address
   input wire logic avs_read, // read
   input wire logic avs_write, // write
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // lanes
   input wire logic [31:0] avs_readdata, // read data
   input wire logic avs_waitrequest, // wait
   input wire sffd_pkg::sffd_result_type result, // sample out
   input wire logic tone_shift_sel_hi, // tone upper
   input wire logic tone_shift_sel_lo // tone lower
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [15:0] gap;
   logic seen;
   wire acc = avs_write && !avs_waitrequest && avs_address == 4'h0;
   // shortest legal spacing is 32 clocks: 8 ticks of 4 clocks, or 4 ticks of 8 in low-power mode
   always_ff @(posedge clk) begin
      if (srst || result.valid) gap <= 16'h0000;
      else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
      if (srst) seen <= 1'b0;
      else if (result.valid) seen <= 1'b1;
   end
   property p_valid_one; result.valid |=> !result.valid; endproperty
   a_valid_one: assert property (p_valid_one) else $error("valid longer than one cycle");
   property p_gap; result.valid && seen |-> gap >= 16'h001F; endproperty
   a_gap: assert property (p_gap) else $error("samples too close");
   property p_tone_rst; $fell(srst) |-> !tone_shift_sel_hi && !tone_shift_sel_lo; endproperty
   a_tone_rst: assert property (p_tone_rst) else $error("tone on after reset");
   property p_tone_lo;
      acc && avs_byteenable[0] |=> tone_shift_sel_lo == $past(avs_writedata[7]);
   endproperty
   a_tone_lo: assert property (p_tone_lo) else $error("tone lower not written");
   property p_tone_hi;
      acc && avs_byteenable[1] |=> tone_shift_sel_hi == $past(avs_writedata[8]);
   endproperty
   a_tone_hi: assert property (p_tone_hi) else $error("tone upper not written");
   property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_answer: assert property (p_answer) else $error("request not answered");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("answer held too long");
   property p_unmapped;
      avs_read && avs_waitrequest && avs_address == 4'hC |=> avs_readdata == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rst; $fell(srst) |-> avs_waitrequest && !result.valid; endproperty
   a_rst: assert property (p_rst) else $error("outputs busy after reset");
   c_valid: cover property (result.valid && seen);
   c_write: cover property (acc);
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule
`default_nettype wire

// ===== sffd_mod_src.sv
// modulator bitstream source for the filter bench
`timescale 1ns/1ps
`default_nettype none
module sffd_mod_src (
   input wire logic clk, // clock
   input wire logic srst, // reset
   input wire logic level, // density: one is all ones
   output logic mod_bit // modulator bit
);
   // a constant density gives an exactly known filter output
   always_ff @(posedge clk) begin
      if (srst) mod_bit <= 1'b0;
      else mod_bit <= level; // no idle-tone offset rides on the stream
   end
endmodule
`default_nettype wire

// ===== sffd_filter_tb.sv
// self-checking bench for the decimation filter
`timescale 1ns/1ps
`include "sffd_cfg.svh"
`default_nettype none
module sffd_filter_tb;
   logic clk, srst, level, mod_bit, avs_read, avs_write, avs_waitrequest;
   logic tone_shift_sel_hi, tone_shift_sel_lo;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd;
   sffd_pkg::sffd_result_type result;
   int err_total, comparisons, n;
   logic [5:0] tab [11] = '{6'h01, 6'h05, 6'h09, 6'h0D, 6'h11, 6'h21, 6'h31,
      6'h12, 6'h0E, 6'h32, 6'h13};
   sffd_filter sffd_filter_inst (.clk(clk), .srst(srst), .mod_bit(mod_bit),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .result(result),
      .tone_shift_sel_hi(tone_shift_sel_hi), .tone_shift_sel_lo(tone_shift_sel_lo));
   sffd_mod_src sffd_mod_src_inst (.clk(clk), .srst(srst), .level(level), .mod_bit(mod_bit));
   task close_out;
      if (err_total == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task give_up;
      err_total++;
      close_out;
   endtask
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (k >= 50) give_up;
   endtask
   task wait_valid(input int lim);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (result.valid !== 1'b1 && n < lim);
      if (n >= lim) give_up;
   endtask
   function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] r,
      input logic lp, input logic ph);
      cfg = {16'h0000, 4'h8, 5'h00, lp, ph, r, m};
   endfunction
   task t_reset;
      check({30'h0, tone_shift_sel_hi, tone_shift_sel_lo}, 32'h0);
      bus(1'b0, `SFFD_ADDR_CTRL, 32'h0);
      check(rd, 32'h00008002);
      bus(1'b0, `SFFD_ADDR_STATUS, 32'h0);
      check({29'h0, rd[2:0]}, 32'h7);
      bus(1'b0, 4'hC, 32'h0);
      check(rd, 32'h0);
   endtask
   task t_rates;
      int nn, p;
      for (int i = 0; i < 11; i++) begin
         nn = (tab[i][5] ? 64 : 128) >> tab[i][4:2];
         p = nn * (tab[i][5] ? 8 : 4) * (tab[i][1:0] >= 2'h2 ? 32 : 1);
         bus(1'b1, `SFFD_ADDR_CTRL, cfg(tab[i][1:0], tab[i][4:2], tab[i][5], i[0]));
         wait_valid(20000);
         wait_valid(20000);
         wait_valid(20000);
         check(32'(n), 32'(p));
         bus(1'b0, `SFFD_ADDR_STATUS, 32'h0);
         check({29'h0, rd[2:0]}, 32'(((tab[i][5]) ? 6 : 7) - tab[i][4:2]));
      end
   endtask
   task t_value;
      level <= 1'b1;
      bus(1'b1, `SFFD_ADDR_CTRL, cfg(2'h1, 3'h4, 1'b0, 1'b0));
      repeat (8) wait_valid(200);
      check({8'h00, result.data}, 32'h00400000);
      level <= 1'b0;
      repeat (8) wait_valid(200);
      check({8'h00, result.data}, 32'h00C00000);
      bus(1'b0, `SFFD_ADDR_DATA, 32'h0);
      check(rd, 32'hFFC00000);
   endtask
   task t_reserved;
      // reserved codes must keep the running rate while tone bits still land
      bus(1'b1, `SFFD_ADDR_CTRL, cfg(2'h1, 3'h5, 1'b0, 1'b0) | 32'h80);
      @(posedge clk);
      check({30'h0, tone_shift_sel_hi, tone_shift_sel_lo}, 32'h1);
      wait_valid(200);
      wait_valid(200);
      check(32'(n), 32'd32);
      bus(1'b1, `SFFD_ADDR_CTRL, cfg(2'h0, 3'h0, 1'b0, 1'b0) | 32'h100);
      @(posedge clk);
      check({30'h0, tone_shift_sel_hi, tone_shift_sel_lo}, 32'h2);
      wait_valid(200);
      wait_valid(200);
      check(32'(n), 32'd32);
      bus(1'b0, `SFFD_ADDR_STATUS, 32'h0);
      check({29'h0, rd[2:0]}, 32'h3);
   endtask
   task t_restart;
      bus(1'b1, `SFFD_ADDR_CTRL, cfg(2'h1, 3'h0, 1'b0, 1'b0));
      wait_valid(2000);
      repeat (100) @(posedge clk);
      bus(1'b1, `SFFD_ADDR_CTRL, cfg(2'h1, 3'h4, 1'b0, 1'b0));
      wait_valid(600);
      check({31'h0, n >= 32 && n <= 48}, 32'h1);
   endtask
   task t_lanes;
      // only lane 1 is written: tone upper bit and dc shift clear, filter setting stays
      avs_byteenable <= 4'h2;
      bus(1'b1, `SFFD_ADDR_CTRL, 32'h0000_0000);
      avs_byteenable <= 4'hF;
      bus(1'b0, `SFFD_ADDR_CTRL, 32'h0);
      check(rd, 32'h00000011);
   endtask
   task t_lowpass;
      // level is low: every settled output is minus full scale
      bus(1'b1, `SFFD_ADDR_CTRL, cfg(2'h2, 3'h4, 1'b0, 1'b1));
      repeat (3) wait_valid(2000);
      check({8'h00, result.data}, 32'h00C00000);
      // dc shift 0: the output is the step between two low-pass samples
      bus(1'b1, `SFFD_ADDR_CTRL, cfg(2'h3, 3'h4, 1'b0, 1'b0) & 32'hFFFF0FFF);
      repeat (4) wait_valid(2000);
      check({8'h00, result.data}, 32'h00000000);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      srst = 1'b1;
      level = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      err_total = 0;
      comparisons = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_reset;
      t_rates;
      t_value;
      t_reserved;
      t_lanes;
      t_restart;
      t_lowpass;
      close_out;
   end
endmodule
bind sffd_filter sffd_filter_sva sffd_filter_sva_inst (.clk(clk), .srst(srst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .result(result),
   .tone_shift_sel_hi(tone_shift_sel_hi), .tone_shift_sel_lo(tone_shift_sel_lo));
`default_nettype wire
